// ===== pcr_bank.sv
// Power control register bank with two-wire serial slave and timed regulator sequencer.
//
// Notes on behaviour
// - Fourteen 8-bit registers; thermal and valid-status read-only, rest read/write.
// - Thermal register bit 1 reads 1 above 125 C; reset 0; others reserved.
// - System control bits 6-4 hold delay preset, reset 010; bit 3 resets set.
// - Delay preset selects per-regulator turn-on delays from the fixed table.
// - Bits 2 and 1 force PWM on converter2 and converter1; reset 0.
// - Bit 0 selects external 13 MHz clock over internal 2 MHz; reset 0.
// - Enable register even bits enable regulators, reset 1; odd bits reserved.
// - Valid-status register reports per-regulator and combined valid flags; reset 0.
// - Write is slave address 0x60, register byte, data byte; each acknowledged.
// - Regulator on when enable bit set and pin enable or its delayed sequencer output high.
// - Deglitched trigger rise starts power-on, fall starts shutdown sequence.
`timescale 1ns/10ps
module pcr_bank #(
	parameter int STEP_CNT = pcr_pkg::STEP_CYCLES,
	parameter int DEGLITCH_CNT = pcr_pkg::DEGLITCH_CYCLES
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA,
	output logic O_SDA_OE_N,
	input wire logic I_SEQ_TRIGGER,
	input wire logic I_CONVERTER1_PIN_ENABLE,
	input wire logic I_CONVERTER2_PIN_ENABLE,
	input wire logic I_LINEAR1_PIN_ENABLE,
	input wire logic I_LINEAR2_PIN_ENABLE,
	input wire logic I_CONVERTER1_VALID,
	input wire logic I_CONVERTER2_VALID,
	input wire logic I_LINEAR1_VALID,
	input wire logic I_LINEAR2_VALID,
	input wire logic I_OVER_TEMP,
	output logic O_CONVERTER1_ON,
	output logic O_CONVERTER2_ON,
	output logic O_LINEAR1_ON,
	output logic O_LINEAR2_ON,
	output logic O_BUCK1_FORCED_PWM,
	output logic O_BUCK2_FORCED_PWM,
	output logic O_BUCK_CLOCK_SOURCE_SELECT
);
	import pcr_pkg::*;

	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} pcr_state_t;

	logic [11:0] sync_level;
	logic scl;
	logic sda;
	logic trig_sync;
	logic [3:0] pin_en;
	logic [3:0] valid_in;
	logic over_temp;

	pcr_sync #(.WIDTH(12), .RESET_VAL(12'h003)) u_sync (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.i_async({I_OVER_TEMP, I_LINEAR2_VALID, I_LINEAR1_VALID, I_CONVERTER2_VALID, I_CONVERTER1_VALID,
			I_LINEAR2_PIN_ENABLE, I_LINEAR1_PIN_ENABLE, I_CONVERTER2_PIN_ENABLE, I_CONVERTER1_PIN_ENABLE,
			I_SEQ_TRIGGER, I_SDA, I_SCL}),
		.o_level(sync_level)
	);

	assign scl = sync_level[0];
	assign sda = sync_level[1];
	assign trig_sync = sync_level[2];
	assign pin_en = sync_level[6:3];
	assign valid_in = sync_level[10:7];
	assign over_temp = sync_level[11];
	// Open-drain: the pin is only ever pulled low.
	assign O_SDA = 1'b0;

	function automatic logic [3:0] find_index(input logic [7:0] addr);
		logic [3:0] r;
		r = REG_NONE;
		for (int k = 0; k < REG_COUNT; k++) begin
			if (REG_ADDR[k] == addr) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction : find_index

	// Serial slave state.
	pcr_state_t state, next_state;
	logic scl_d, sda_d;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shift, next_shift;
	logic [7:0] ptr, next_ptr;
	logic rw, next_rw;
	logic oe_n, next_oe_n;
	logic wr_en, next_wr_en;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [7:0] rd_data;
	logic [3:0] ptr_idx;

	// Register bank state.
	logic [7:0] bank [0:13];
	logic [7:0] next_bank [0:13];
	logic [7:0] valid_status, next_valid_status;

	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_cond = scl & scl_d & sda_d & ~sda;
	assign stop_cond = scl & scl_d & ~sda_d & sda;
	assign ptr_idx = find_index(ptr);

	always_comb begin
		if (ptr_idx == IDX_THERMAL) begin
			rd_data = 8'h00;
			rd_data[THERMAL_BIT] = over_temp;
		end else if (ptr_idx == IDX_VALID_STATUS) begin
			rd_data = valid_status;
		end else if (ptr_idx == REG_NONE) begin
			rd_data = 8'h00;
		end else begin
			rd_data = bank[ptr_idx];
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shift = shift;
		next_ptr = ptr;
		next_rw = rw;
		next_oe_n = oe_n;
		next_wr_en = 1'b0;
		if (start_cond) begin
			next_state = ST_ADDR;
			next_cnt = 4'h0;
			next_oe_n = 1'b1;
		end else if (stop_cond) begin
			next_state = ST_IDLE;
			next_oe_n = 1'b1;
		end else begin
			case (state)
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise && cnt != 4'h8) begin
						next_shift = {shift[6:0], sda};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						next_cnt = 4'h0;
						if (state == ST_ADDR) begin
							if (shift[7:1] == SLAVE_ADDR) begin
								next_oe_n = 1'b0;
								next_rw = shift[0];
								next_state = ST_ADDR_ACK;
							end else begin
								next_state = ST_IDLE;
							end
						end else if (state == ST_REG) begin
							next_ptr = shift;
							next_oe_n = 1'b0;
							next_state = ST_REG_ACK;
						end else begin
							next_wr_en = 1'b1;
							next_oe_n = 1'b0;
							next_state = ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							next_oe_n = rd_data[7];
							next_shift = {rd_data[6:0], 1'b0};
							next_cnt = 4'h1;
							next_state = ST_RDATA;
						end else begin
							next_oe_n = 1'b1;
							next_state = ST_REG;
						end
					end
				end
				ST_REG_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_oe_n = 1'b1;
						next_state = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (cnt == 4'h8) begin
							next_oe_n = 1'b1;
							next_state = ST_RACK;
						end else begin
							next_oe_n = shift[7];
							next_shift = {shift[6:0], 1'b0};
							next_cnt = cnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					// A not-acknowledge ends the read; an acknowledge resends the same register.
					if (scl_rise && sda) begin
						next_state = ST_IDLE;
					end else if (scl_fall) begin
						next_oe_n = rd_data[7];
						next_shift = {rd_data[6:0], 1'b0};
						next_cnt = 4'h1;
						next_state = ST_RDATA;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state <= ST_IDLE;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			oe_n <= 1'b1;
			wr_en <= 1'b0;
		end else begin
			state <= next_state;
			scl_d <= scl;
			sda_d <= sda;
			cnt <= next_cnt;
			shift <= next_shift;
			ptr <= next_ptr;
			rw <= next_rw;
			oe_n <= next_oe_n;
			wr_en <= next_wr_en;
		end
	end

	assign O_SDA_OE_N = oe_n;

	always_comb begin
		next_bank = bank;
		if (wr_en && ptr_idx != REG_NONE) begin
			next_bank[ptr_idx] = (bank[ptr_idx] & ~REG_WMASK[ptr_idx]) | (shift & REG_WMASK[ptr_idx]);
		end
		next_valid_status = 8'h00;
		next_valid_status[CONV1_VALID_BIT] = valid_in[0];
		next_valid_status[CONV2_VALID_BIT] = valid_in[1];
		next_valid_status[LIN1_VALID_BIT] = valid_in[2];
		next_valid_status[LIN2_VALID_BIT] = valid_in[3];
		next_valid_status[LINS_ALL_BIT] = valid_in[2] & valid_in[3];
		next_valid_status[CONVS_ALL_BIT] = valid_in[0] & valid_in[1];
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bank <= REG_RESET;
			valid_status <= 8'h00;
		end else begin
			bank <= next_bank;
			valid_status <= next_valid_status;
		end
	end

	// Trigger deglitch and sequencer.
	logic trig_dg, next_trig_dg;
	logic [19:0] dg_cnt, next_dg_cnt;
	logic [19:0] tick, next_tick;
	logic [4:0] steps, next_steps;
	logic [3:0] seq_on, next_seq_on;
	logic [3:0] reg_on, next_reg_on;
	logic [2:0] delay_sel;

	assign delay_sel = bank[IDX_SYS_CTRL][DELAY_SEL_LSB +: 3];

	always_comb begin
		next_trig_dg = trig_dg;
		next_dg_cnt = 20'h0;
		next_tick = tick;
		next_steps = steps;
		next_seq_on = seq_on;
		if (trig_sync != trig_dg) begin
			next_dg_cnt = dg_cnt + 20'h1;
			if (dg_cnt == 20'(DEGLITCH_CNT - 1)) begin
				next_trig_dg = trig_sync;
				next_dg_cnt = 20'h0;
			end
		end
		if (next_trig_dg != trig_dg) begin
			next_tick = 20'h0;
			next_steps = 5'h00;
		end else if (tick == 20'(STEP_CNT - 1)) begin
			next_tick = 20'h0;
			if (steps != 5'h1f) begin
				next_steps = steps + 5'h01;
			end
		end else begin
			next_tick = tick + 20'h1;
		end
		// Both directions share the table; the shutdown walks the same delays.
		for (int k = 0; k < 4; k++) begin
			if (steps >= DELAY_HALF_MS[delay_sel][k]) begin
				next_seq_on[k] = trig_dg;
			end
			next_reg_on[k] = bank[IDX_REG_ENABLE][2 * k] & (pin_en[k] | seq_on[k]);
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			trig_dg <= 1'b0;
			dg_cnt <= 20'h0;
			tick <= 20'h0;
			steps <= 5'h1f;
			seq_on <= 4'h0;
			reg_on <= 4'h0;
		end else begin
			trig_dg <= next_trig_dg;
			dg_cnt <= next_dg_cnt;
			tick <= next_tick;
			steps <= next_steps;
			seq_on <= next_seq_on;
			reg_on <= next_reg_on;
		end
	end

	assign O_CONVERTER1_ON = reg_on[0];
	assign O_CONVERTER2_ON = reg_on[1];
	assign O_LINEAR1_ON = reg_on[2];
	assign O_LINEAR2_ON = reg_on[3];
	assign O_BUCK1_FORCED_PWM = bank[IDX_SYS_CTRL][BUCK1_FPWM_BIT];
	assign O_BUCK2_FORCED_PWM = bank[IDX_SYS_CTRL][BUCK2_FPWM_BIT];
	assign O_BUCK_CLOCK_SOURCE_SELECT = bank[IDX_SYS_CTRL][CLK_SRC_BIT];

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	AST_ACK_ON_MATCH: assert property ((state == ST_ADDR && !start_cond && !stop_cond && scl_fall && cnt == 4'h8
		&& shift[7:1] == SLAVE_ADDR) |=> (!O_SDA_OE_N && state == ST_ADDR_ACK))
		else $error("address match not acknowledged");
	AST_NO_ACK_MISMATCH: assert property ((state == ST_ADDR && !start_cond && !stop_cond && scl_fall && cnt == 4'h8
		&& shift[7:1] != SLAVE_ADDR) |=> (O_SDA_OE_N && state == ST_IDLE))
		else $error("foreign address acknowledged");
	AST_DATA_ACK: assert property ((state == ST_WDATA && !start_cond && !stop_cond && scl_fall && cnt == 4'h8)
		|=> (wr_en && !O_SDA_OE_N))
		else $error("data byte not acknowledged");
	AST_MASKED_WRITE: assert property ((wr_en && ptr_idx == IDX_SYS_CTRL) |=> (bank[IDX_SYS_CTRL] ==
		(($past(shift) & REG_WMASK[IDX_SYS_CTRL]) | (REG_RESET[IDX_SYS_CTRL] & ~REG_WMASK[IDX_SYS_CTRL]))))
		else $error("system control write wrong");
	AST_READ_ONLY_FIXED: assert property (bank[IDX_THERMAL] == 8'h00 && bank[IDX_VALID_STATUS] == 8'h00
		&& (bank[IDX_REG_ENABLE] & 8'haa) == 8'h00)
		else $error("read-only or reserved bits changed");
	AST_THERMAL_READ: assert property ((ptr_idx == IDX_THERMAL) |-> (rd_data == {6'h00, over_temp, 1'b0}))
		else $error("thermal read value wrong");
	AST_COMBINED_VALID: assert property (valid_status[CONVS_ALL_BIT] == (valid_status[CONV1_VALID_BIT]
		& valid_status[CONV2_VALID_BIT]) && valid_status[LINS_ALL_BIT] == (valid_status[LIN1_VALID_BIT]
		& valid_status[LIN2_VALID_BIT]))
		else $error("combined valid flag wrong");
	AST_REG_ON_RULE: assert property (##1 O_LINEAR2_ON == $past(bank[IDX_REG_ENABLE][6] & (pin_en[3] | seq_on[3])))
		else $error("linear2 on state wrong");
	AST_SEQ_RESTART: assert property ($changed(trig_dg) |-> (steps == 5'h00 && tick == 20'h0))
		else $error("sequence did not restart on trigger edge");
	AST_SEQ_TIMING: assert property ((trig_dg && !$changed(trig_dg) && steps == DELAY_HALF_MS[delay_sel][0])
		|=> seq_on[0])
		else $error("converter1 sequence step late");

	COV_WRITE: cover property (wr_en && ptr_idx == IDX_REG_ENABLE);
	COV_READ: cover property (state == ST_RDATA && scl_fall && cnt == 4'h8);
	COV_SEQ_DONE: cover property (trig_dg && seq_on == 4'hf);
	COV_NACK: cover property (state == ST_RACK && scl_rise && sda);

endmodule : pcr_bank

// ===== pcr_pkg.sv
// Shared constants of the power control register bank: map, fields, reset values and timing.
package pcr_pkg;

	localparam int REG_COUNT = 14;
	localparam logic [3:0] REG_NONE = 4'hf;
	localparam logic [6:0] SLAVE_ADDR = 7'h60;

	// Register map, index order matches the arrays below.
	localparam logic [7:0] REG_ADDR [0:13] = '{8'h02, 8'h07, 8'h10, 8'h11, 8'h20, 8'h23, 8'h24,
		8'h25, 8'h29, 8'h2a, 8'h2b, 8'h38, 8'h39, 8'h3a};
	localparam logic [7:0] REG_RESET [0:13] = '{8'h00, 8'h28, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h28, 8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00};
	// Writable bits; everything else keeps its reset value forever.
	localparam logic [7:0] REG_WMASK [0:13] = '{8'h00, 8'h77, 8'h55, 8'h00, 8'h33, 8'h1f, 8'h1f,
		8'h0f, 8'h1f, 8'h1f, 8'h0f, 8'hff, 8'hff, 8'hff};

	localparam logic [3:0] IDX_THERMAL = 4'h0;
	localparam logic [3:0] IDX_SYS_CTRL = 4'h1;
	localparam logic [3:0] IDX_REG_ENABLE = 4'h2;
	localparam logic [3:0] IDX_VALID_STATUS = 4'h3;

	// Field positions.
	localparam int THERMAL_BIT = 1;
	localparam int DELAY_SEL_LSB = 4;
	localparam int BUCK2_FPWM_BIT = 2;
	localparam int BUCK1_FPWM_BIT = 1;
	localparam int CLK_SRC_BIT = 0;
	localparam int CONV1_VALID_BIT = 0;
	localparam int CONV2_VALID_BIT = 2;
	localparam int LIN1_VALID_BIT = 4;
	localparam int LIN2_VALID_BIT = 5;
	localparam int LINS_ALL_BIT = 6;
	localparam int CONVS_ALL_BIT = 7;

	// Power-on/off delays in half-millisecond steps, order converter1, converter2, linear1, linear2.
	localparam logic [4:0] DELAY_HALF_MS [0:7][0:3] = '{
		'{5'h02, 5'h02, 5'h02, 5'h02},
		'{5'h02, 5'h03, 5'h04, 5'h04},
		'{5'h03, 5'h04, 5'h06, 5'h0c},
		'{5'h03, 5'h04, 5'h02, 5'h02},
		'{5'h03, 5'h04, 5'h06, 5'h0c},
		'{5'h03, 5'h03, 5'h04, 5'h04},
		'{5'h06, 5'h04, 5'h02, 5'h03},
		'{5'h04, 5'h06, 5'h0c, 5'h16}};

	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_TIME_NS = 500000;
	localparam int DEGLITCH_TIME_NS = 1000000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int DEGLITCH_CYCLES = DEGLITCH_TIME_NS / CLK_PERIOD_NS;

endpackage : pcr_pkg

// ===== pcr_sync.sv
// Three-stage synchroniser with an agree filter for a bundle of asynchronous inputs.
`timescale 1ns/10ps
module pcr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// A bit only moves once the second and third stages agree, which drops one-cycle metastable blips.
	always_comb begin
		for (int k = 0; k < WIDTH; k++) begin
			next_level[k] = (stage2[k] == stage3[k]) ? stage3[k] : o_level[k];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
			o_level <= RESET_VAL;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
			o_level <= next_level;
		end
	end
endmodule : pcr_sync

// ===== pcr_host.sv
// Two-wire bus host model that writes and reads the register bank.
`timescale 1ns/10ps
module pcr_host (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
	endtask : w

	task automatic bit_out(input logic b);
		w(6);
		o_sda <= b;
		w(6);
		o_scl <= 1'b1;
		w(12);
		o_scl <= 1'b0;
	endtask : bit_out

	task automatic bit_in(output logic b);
		w(6);
		o_sda <= 1'b1;
		w(6);
		o_scl <= 1'b1;
		w(8);
		b = i_sda;
		w(4);
		o_scl <= 1'b0;
	endtask : bit_in

	// The long wait lets a late acknowledge release the line before the clock rises.
	task automatic start();
		w(6);
		o_sda <= 1'b1;
		w(12);
		o_scl <= 1'b1;
		w(12);
		o_sda <= 1'b0;
		w(12);
		o_scl <= 1'b0;
	endtask : start

	task automatic stop();
		w(6);
		o_sda <= 1'b0;
		w(6);
		o_scl <= 1'b1;
		w(12);
		o_sda <= 1'b1;
		w(12);
	endtask : stop

	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(a);
		ack = ~a;
	endtask : byte_out

	task automatic xfer(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] ack);
		start();
		byte_out(dev, ack[2]);
		byte_out(ra, ack[1]);
		byte_out(d, ack[0]);
		stop();
	endtask : xfer

	task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic [2:0] ack);
		start();
		byte_out(8'hc0, ack[2]);
		byte_out(ra, ack[1]);
		start();
		byte_out(8'hc1, ack[0]);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(1'b1);
		stop();
	endtask : rd
endmodule : pcr_host

// ===== tb_top.sv
// Self-checking bench for the power control register bank.
`timescale 1ns/10ps
module tb_top;
	import pcr_pkg::*;
	localparam int STEP = 10;
	localparam int DEG = 8;
	// Expected sequence delays in half-millisecond steps per preset.
	localparam int DLY [0:7][0:3] = '{'{2, 2, 2, 2}, '{2, 3, 4, 4}, '{3, 4, 6, 12}, '{3, 4, 2, 2},
		'{3, 4, 6, 12}, '{3, 3, 4, 4}, '{6, 4, 2, 3}, '{4, 6, 12, 22}};
	logic clk;
	logic arst_n;
	logic trig;
	logic ot;
	logic [3:0] pins;
	logic [3:0] valid;
	logic [3:0] on;
	logic scl;
	logic sda_m;
	logic sda_wire;
	logic o_sda;
	logic oe_n;
	logic buck1_forced_pwm;
	logic buck2_forced_pwm;
	logic clksel;
	logic [7:0] shadow [0:13];
	logic [7:0] rdat;
	logic [2:0] ack;
	int t [0:3];
	int failures = 0;
	int checks_done = 0;
	int seed = 32'h9be3;

	assign sda_wire = sda_m & (oe_n | o_sda);

	pcr_bank #(.STEP_CNT(STEP), .DEGLITCH_CNT(DEG)) i_pcr_bank (.I_CLK(clk), .I_ARST_N(arst_n), .I_SCL(scl),
		.I_SDA(sda_wire), .O_SDA(o_sda), .O_SDA_OE_N(oe_n), .I_SEQ_TRIGGER(trig),
		.I_CONVERTER1_PIN_ENABLE(pins[0]), .I_CONVERTER2_PIN_ENABLE(pins[1]), .I_LINEAR1_PIN_ENABLE(pins[2]),
		.I_LINEAR2_PIN_ENABLE(pins[3]), .I_CONVERTER1_VALID(valid[0]), .I_CONVERTER2_VALID(valid[1]),
		.I_LINEAR1_VALID(valid[2]), .I_LINEAR2_VALID(valid[3]), .I_OVER_TEMP(ot), .O_CONVERTER1_ON(on[0]),
		.O_CONVERTER2_ON(on[1]), .O_LINEAR1_ON(on[2]), .O_LINEAR2_ON(on[3]), .O_BUCK1_FORCED_PWM(buck1_forced_pwm),
		.O_BUCK2_FORCED_PWM(buck2_forced_pwm), .O_BUCK_CLOCK_SOURCE_SELECT(clksel));

	pcr_host i_pcr_host (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(sda_m));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	function automatic logic [7:0] exp_reg(input int k);
		if (k == 0) return {6'h00, ot, 1'b0};
		if (k == 3) return {valid[0] & valid[1], valid[2] & valid[3], valid[3], valid[2], 1'b0, valid[1], 1'b0, valid[0]};
		return shadow[k];
	endfunction : exp_reg

	task automatic rdchk(input logic [7:0] ra, input logic [7:0] e);
		i_pcr_host.rd(ra, rdat, ack);
		check(ack, 3'h7);
		check(rdat, e);
	endtask : rdchk

	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		i_pcr_host.xfer(8'hc0, ra, d, ack);
		check(ack, 3'h7);
		for (int k = 0; k < REG_COUNT; k++) begin
			if (REG_ADDR[k] == ra) shadow[k] = (shadow[k] & ~REG_WMASK[k]) | (d & REG_WMASK[k]);
		end
	endtask : wr

	// Records the cycle at which each regulator output first reaches the given level.
	task automatic tmeas(input logic v);
		for (int k = 0; k < 4; k++) t[k] = -1;
		for (int c = 1; c <= 300; c++) begin
			@(posedge clk);
			#1;
			for (int k = 0; k < 4; k++) begin
				if (t[k] < 0 && on[k] === v) t[k] = c;
			end
		end
	endtask : tmeas

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		// The full run needs roughly 65000 cycles; this leaves margin while staying below 100000.
		repeat (95000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		arst_n = 1'b0;
		trig = 1'b0;
		ot = 1'b0;
		pins = 4'h0;
		valid = 4'h0;
		for (int k = 0; k < REG_COUNT; k++) shadow[k] = REG_RESET[k];
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		check({buck2_forced_pwm, buck1_forced_pwm, clksel}, 3'h0);
		for (int k = 0; k < REG_COUNT; k++) rdchk(REG_ADDR[k], exp_reg(k));
		rdchk(8'h05, 8'h00);
		for (int k = 0; k < REG_COUNT; k++) wr(REG_ADDR[k], 8'($random(seed)));
		for (int k = 0; k < REG_COUNT; k++) rdchk(REG_ADDR[k], exp_reg(k));
		check({buck2_forced_pwm, buck1_forced_pwm, clksel}, shadow[1][2:0]);
		i_pcr_host.xfer(8'hc2, 8'h07, 8'hff, ack);
		check(ack, 3'h0);
		rdchk(8'h07, shadow[1]);
		for (int n = 0; n < 4; n++) begin
			ot <= 1'($random(seed));
			valid <= 4'($random(seed));
			repeat (8) @(posedge clk);
			rdchk(8'h02, exp_reg(0));
			rdchk(8'h11, exp_reg(3));
		end
		for (int n = 0; n < 4; n++) begin
			pins <= 4'($random(seed));
			wr(8'h10, 8'($random(seed)));
			repeat (10) @(posedge clk);
			check(on, {shadow[2][6], shadow[2][4], shadow[2][2], shadow[2][0]} & pins);
		end
		// Pin enables stay low so only the timed sequence can turn regulators on.
		pins <= 4'h0;
		wr(8'h10, 8'h55);
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
		repeat (60) @(posedge clk);
		check(on, 4'h0);
		for (int s = 0; s < 8; s++) begin
			wr(8'h07, {1'b0, 3'(s), 4'h0});
			check({buck2_forced_pwm, buck1_forced_pwm, clksel}, 3'h0);
			for (int e = 1; e >= 0; e--) begin
				trig <= e[0];
				tmeas(e[0]);
				for (int k = 0; k < 4; k++) begin
					check(t[k] >= DLY[s][k] * STEP + DEG && t[k] <= DLY[s][k] * STEP + DEG + 9, 1);
				end
			end
		end
		results();
	end
endmodule : tb_top
